// >>> orad_map.vh
// Functional notes
// - 8 kbytes storage on 16-bit core path.
// - Modes 1,2,5,7 window H'FDF10 to H'FFF0F.
// - Modes 3,4,6 window H'FFDF10 to H'FFFF0F.
// - System control bit 0 enables storage, resets 1.
// - Enable restored by chip reset, kept in standby.
// - Enabled window accesses go to on-chip storage.
// - Modes 1-6 disabled window accesses go external.
// - Mode 7 disabled: reads H'FF, writes ignored.
// - Byte access: two states, upper data lane.
// - Even word access: two states, all 16 bits.
`ifndef ORAD_MAP_VH
`define ORAD_MAP_VH

// Register indices as printed; the AHB byte address is four times the index.
`define ORAD_SYSCTL_IDX 16'hfff2
`define ORAD_STATUS_IDX 16'hfff3
`define ORAD_SYSCTL_RST 8'h0b
`define ORAD_ENABLE_BIT 0

// Status register field positions.
`define ORAD_ST_MODE_LO 0
`define ORAD_ST_ENABLE 3
`define ORAD_ST_RAM 4
`define ORAD_ST_EXT 5
`define ORAD_ST_BLANK 6
`define ORAD_ST_BUSY 7

// Address windows of the storage.
`define ORAD_NARROW_LO 20'hfdf10
`define ORAD_NARROW_HI 20'hfff0f
`define ORAD_WIDE_LO 24'hffdf10
`define ORAD_WIDE_HI 24'hffff0f

// Storage geometry: 4096 words of 16 bits.
`define ORAD_MEM_AW 12
`define ORAD_MEM_DEPTH 4096
`define ORAD_BLANK_WORD 16'hffff

// Mode numbers.
`define ORAD_MODE_SINGLE 3'h7

`endif

// >>> orad_mem.v
`timescale 1ns/100ps
`include "orad_map.vh"

module orad_mem (
    // Clock.
    input wire ref_clk,
    // Access port.
    input wire en,
    input wire we,
    input wire [1:0] be,
    input wire [`ORAD_MEM_AW-1:0] addr,
    input wire [15:0] wdata,
    // Registered read data.
    output reg [15:0] rdata_q
);

    reg [15:0] mem [0:`ORAD_MEM_DEPTH-1];

    // Byte enables let a byte write leave the other half of the word intact.
    always @(posedge ref_clk) begin
        if (en) begin
            if (we && be[1]) begin
                mem[addr][15:8] <= wdata[15:8];
            end
            if (we && be[0]) begin
                mem[addr][7:0] <= wdata[7:0];
            end
            rdata_q <= mem[addr];
        end
    end

endmodule // orad_mem

// >>> orad_top.v
`timescale 1ns/100ps
`include "orad_map.vh"

module orad_top (
    // Clock and reset.
    input wire ref_clk,
    input wire rstn,
    // Operating mode from the chip mode logic.
    input wire [2:0] op_mode,
    // Core access port.
    input wire cpu_req,
    input wire cpu_we,
    input wire cpu_byte,
    input wire [23:0] cpu_addr,
    input wire [15:0] cpu_wdata,
    output reg cpu_done_q,
    output reg [15:0] cpu_rdata_q,
    // External bus hand-off.
    output reg ext_req_q,
    output reg ext_we_q,
    output reg ext_byte_q,
    output reg [23:0] ext_addr_q,
    output reg [15:0] ext_wdata_q,
    input wire ext_done,
    input wire [15:0] ext_rdata,
    // AHB-Lite register slave.
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp
);

    // One-hot access states; each state has a single bit set, so a stray
    // code is easy to spot and the default branch recovers from it.
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_RAM = 3'b010;
    localparam [2:0] ST_EXT = 3'b100;

    // Sequencer state and the control register.
    reg [2:0] state_q;
    reg [7:0] sysctl_q;
    // Context of the access in flight, captured at the take edge.
    reg blank_q;
    reg byte_q;
    reg odd_q;
    // Where the last access went, kept for the status register.
    reg last_ram_q;
    reg last_ext_q;
    reg last_blank_q;
    // AHB data-phase context, captured when an address phase is accepted.
    reg dp_valid_q;
    reg dp_write_q;
    reg dp_ctl_q;

    // Decode and storage port nets.
    wire storage_enable_bit;
    wire [15:0] mem_rdata;
    wire [13:0] win;
    wire hit;
    wire take;
    wire go_ram;
    wire go_blank;
    wire mem_en;
    wire mem_we;
    wire [1:0] mem_be;
    wire [15:0] mem_wdata;
    // Register bus nets.
    wire ahb_take;
    wire ctl_wr;
    wire [7:0] ctl_now;
    wire [7:0] status;

    // Window decode: bit 13 is the hit flag, the low 13 bits the byte offset.
    // The narrow modes see a 20-bit space, so only the low 20 address bits count.
    // Both windows span exactly 8 kbytes, so the offset always fits in 13 bits
    // and needs no further range check once the hit flag is set.
    // Mode 0 and any other unlisted code give no window at all; such accesses
    // are handed to the external bus like any address outside the window.
    function [13:0] win_decode;
        input [2:0] mode;
        input [23:0] a;
        reg [19:0] off_n;
        reg [23:0] off_w;
        begin
            // Offsets are worked out for both windows; the mode picks which one counts.
            off_n = a[19:0] - `ORAD_NARROW_LO;
            off_w = a - `ORAD_WIDE_LO;
            win_decode = 14'h0000;
            case (mode)
                3'h1, 3'h2, 3'h5, 3'h7: begin
                    if (a[19:0] >= `ORAD_NARROW_LO && a[19:0] <= `ORAD_NARROW_HI) begin
                        win_decode = {1'b1, off_n[12:0]};
                    end
                end
                3'h3, 3'h4, 3'h6: begin
                    if (a >= `ORAD_WIDE_LO && a <= `ORAD_WIDE_HI) begin
                        win_decode = {1'b1, off_w[12:0]};
                    end
                end
                default: begin
                    win_decode = 14'h0000;
                end
            endcase
        end
    endfunction

    // Register decode: the byte address is four times the register index.
    // Upper address bits must be zero, so no alias of a register appears higher up.
    function reg_hit;
        input [31:0] a;
        input [15:0] idx;
        begin
            reg_hit = (a[31:18] == 14'h0000) && (a[17:2] == idx);
        end
    endfunction

    // Routing of a taken request: storage when enabled and in the window, a
    // blank answer in single-chip mode when disabled, and the external bus
    // for everything else.
    assign storage_enable_bit = sysctl_q[`ORAD_ENABLE_BIT];
    assign win = win_decode(op_mode, cpu_addr);
    assign hit = win[13];
    assign take = cpu_req && (state_q == ST_IDLE);
    assign go_ram = take && hit && storage_enable_bit;
    assign go_blank = take && hit && !storage_enable_bit && (op_mode == `ORAD_MODE_SINGLE);

    // Storage port is driven straight from the request so the read data is
    // registered by the first edge and the answer lands one state later.
    // The trade-off is a combinational path from the core request pins into
    // the storage enable; it buys the two-state answer without a wait state.
    // A byte write puts the byte on both lanes and lets the lane enable pick
    // the half selected by address bit 0.
    assign mem_en = go_ram;
    assign mem_we = go_ram && cpu_we;
    assign mem_be = cpu_byte ? (cpu_addr[0] ? 2'b01 : 2'b10) : 2'b11;
    assign mem_wdata = cpu_byte ? {cpu_wdata[15:8], cpu_wdata[15:8]} : cpu_wdata;

    // 4096 x 16 words give the 8 kbytes on a 16-bit path.
    // The memory answers with registered data; it has no reset, so its words
    // start undefined until written.
    orad_mem u_mem (
        .ref_clk(ref_clk),
        .en(mem_en),
        .we(mem_we),
        .be(mem_be),
        .addr(win[12:1]),
        .wdata(mem_wdata),
        .rdata_q(mem_rdata)
    );

    // Access sequencer; a request is only taken while idle, the core waits for done.
    // Storage and blank accesses: the take edge moves to the second state, and
    // the edge after it raises done with the read data for one cycle.
    // External accesses: the take edge raises the request pulse for one cycle,
    // and done follows the edge at which the external bus answers.
    // A request made while busy is dropped, not queued, so the core must
    // wait for done before it asks again.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            // All outputs start low; the core sees no done until it asks.
            state_q <= ST_IDLE;
            cpu_done_q <= 1'b0;
            cpu_rdata_q <= 16'h0000;
            blank_q <= 1'b0;
            byte_q <= 1'b0;
            odd_q <= 1'b0;
            ext_req_q <= 1'b0;
            ext_we_q <= 1'b0;
            ext_byte_q <= 1'b0;
            ext_addr_q <= 24'h000000;
            ext_wdata_q <= 16'h0000;
            last_ram_q <= 1'b0;
            last_ext_q <= 1'b0;
            last_blank_q <= 1'b0;
        end else begin
            cpu_done_q <= 1'b0;
            ext_req_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        // Context is kept for the answer state and for status.
                        byte_q <= cpu_byte;
                        odd_q <= cpu_addr[0];
                        blank_q <= go_blank;
                        last_ram_q <= go_ram;
                        last_blank_q <= go_blank;
                        last_ext_q <= !(go_ram || go_blank);
                        // Local answers take the second state; the rest go out.
                        if (go_ram || go_blank) begin
                            state_q <= ST_RAM;
                        end else begin
                            // Disabled window in expanded modes, and any
                            // address outside the window, go to the external bus.
                            ext_req_q <= 1'b1;
                            ext_we_q <= cpu_we;
                            ext_byte_q <= cpu_byte;
                            ext_addr_q <= cpu_addr;
                            ext_wdata_q <= cpu_wdata;
                            state_q <= ST_EXT;
                        end
                    end
                end
                ST_RAM: begin
                    // Second state: the answer is out, for byte and word alike.
                    // Byte reads move the addressed byte to the upper lane.
                    // The blank answer ignores whatever the storage read gave.
                    cpu_done_q <= 1'b1;
                    if (blank_q) begin
                        cpu_rdata_q <= `ORAD_BLANK_WORD;
                    end else if (byte_q) begin
                        cpu_rdata_q <= {odd_q ? mem_rdata[7:0] : mem_rdata[15:8], 8'h00};
                    end else begin
                        cpu_rdata_q <= mem_rdata;
                    end
                    state_q <= ST_IDLE;
                end
                ST_EXT: begin
                    // The external answer is passed through unchanged; the
                    // sequencer waits here for as long as the external bus takes.
                    if (ext_done) begin
                        cpu_done_q <= 1'b1;
                        cpu_rdata_q <= ext_rdata;
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    // An illegal state code falls back to idle rather than locking up.
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // AHB address phase is accepted every time; the slave never inserts waits.
    // Read data is registered at the accepting edge, so it stands through the
    // data phase and is zero in every other cycle.
    // Unmapped addresses read zero and ignore writes; the answer is always OKAY.
    // The transfer size is not decoded: every access is taken as a whole word.
    assign ahb_take = hsel && htrans[1] && hready;
    // A control write is flagged in its data phase from the captured address.
    assign ctl_wr = dp_valid_q && dp_write_q && dp_ctl_q;
    // A read right behind a write sees the value being written.
    assign ctl_now = ctl_wr ? hwdata[7:0] : sysctl_q;

    // Status layout, read only: busy, last routing taken and the live mode.
    assign status = {
        state_q != ST_IDLE, // Busy.
        last_blank_q, // Last access answered blank.
        last_ext_q, // Last access sent to the external bus.
        last_ram_q, // Last access served by the storage.
        storage_enable_bit, // Live enable bit.
        op_mode // Live operating mode number.
    };

    // Address phase capture and read data, registered for the data phase.
    // A write is applied at the end of its data phase, when hwdata stands.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            // The bus is ready from reset on.
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_ctl_q <= 1'b0;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            // The slave never stalls and never signals an error.
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            dp_valid_q <= ahb_take;
            dp_write_q <= hwrite;
            dp_ctl_q <= reg_hit(haddr, `ORAD_SYSCTL_IDX);
            hrdata <= 32'h00000000;
            if (ahb_take && !hwrite) begin
                if (reg_hit(haddr, `ORAD_SYSCTL_IDX)) begin
                    hrdata <= {24'h000000, ctl_now};
                end else if (reg_hit(haddr, `ORAD_STATUS_IDX)) begin
                    hrdata <= {24'h000000, status};
                end
            end
        end
    end

    // Only the chip reset restores the control register; standby has no path
    // here, so the enable bit survives it unchanged.
    // All eight bits are kept and read back, though only bit 0 acts here.
    // Writes take effect at the end of the data phase, like any register.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sysctl_q <= `ORAD_SYSCTL_RST;
        end else if (ctl_wr) begin
            sysctl_q <= hwdata[7:0];
        end
    end

endmodule // orad_top

// >>> orad_checker.sv
`timescale 1ns/100ps
`include "orad_map.vh"
module orad_checker (
    // Clock and reset.
    input wire ref_clk,
    input wire rstn,
    // Core side.
    input wire [2:0] op_mode,
    input wire cpu_req,
    input wire cpu_we,
    input wire [23:0] cpu_addr,
    input wire cpu_done_q,
    input wire [15:0] cpu_rdata_q,
    input wire ext_req_q,
    input wire [23:0] ext_addr_q,
    input wire ext_done,
    // Register bus.
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp
);
    logic busy_q, wr_q, rd_q, take, win, narrow;
    logic [7:0] sc_q;
    // Decode the window the same way the core sees it, from the mode number.
    assign narrow = op_mode inside {3'h1, 3'h2, 3'h5, 3'h7};
    assign take = cpu_req && !busy_q;
    assign win = narrow ? (cpu_addr[19:0] >= `ORAD_NARROW_LO && cpu_addr[19:0] <= `ORAD_NARROW_HI)
        : (op_mode != 3'h0 && cpu_addr >= `ORAD_WIDE_LO && cpu_addr <= `ORAD_WIDE_HI);
    // Shadow copy of system_control, so routing can be judged from the ports alone.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            busy_q <= 1'b0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            sc_q <= `ORAD_SYSCTL_RST;
        end else begin
            wr_q <= hsel && htrans[1] && hready && hwrite && haddr == 32'h3ffc8;
            rd_q <= hsel && htrans[1] && hready && !hwrite && haddr == 32'h3ffc8;
            if (wr_q)
                sc_q <= hwdata[7:0];
            busy_q <= take ? 1'b1 : (cpu_done_q ? 1'b0 : busy_q);
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence local_s;
        !ext_req_q ##1 cpu_done_q;
    endsequence
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not okay");
    store_local_a: assert property (take && win && sc_q[0] |=> local_s)
        else $error("enabled window access not served locally in two states");
    blank_read_a: assert property (take && win && !sc_q[0] && op_mode == 3'h7 && !cpu_we
        |=> local_s ##0 cpu_rdata_q == 16'hffff) else $error("disabled read not blank");
    fwd_ext_a: assert property (take && win && !sc_q[0] && op_mode inside {[3'h1:3'h6]}
        |=> ext_req_q && ext_addr_q == $past(cpu_addr)) else $error("access not forwarded");
    ext_done_a: assert property (ext_done && busy_q |=> cpu_done_q) else $error("late done");
    done_pulse_a: assert property (cpu_done_q |=> !cpu_done_q) else $error("done too long");
    ext_pulse_a: assert property (ext_req_q |=> !ext_req_q) else $error("ext request too long");
    reg_read_a: assert property (rd_q |-> hrdata == {24'h0, sc_q})
        else $error("system_control read wrong");
endmodule // orad_checker

bind orad_top orad_checker u_chk (.ref_clk, .rstn, .op_mode, .cpu_req, .cpu_we, .cpu_addr,
    .cpu_done_q, .cpu_rdata_q, .ext_req_q, .ext_addr_q, .ext_done, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp);

// >>> orad_ext_model.sv
`timescale 1ns/100ps
module orad_ext_model (
    // Clock and reset.
    input wire ref_clk,
    input wire rstn,
    // Forwarded access from the block.
    input wire ext_req_q,
    input wire [23:0] ext_addr_q,
    // Answer to the block.
    output logic ext_done,
    output wire [15:0] ext_rdata
);
    logic [2:0] wait_q;
    logic live_q;
    logic [15:0] tick_q;
    // Delay comes from address bits, so some replies are prompt and some slow.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            live_q <= 1'b0;
            wait_q <= 3'h0;
            ext_done <= 1'b0;
            tick_q <= 16'h0;
        end else begin
            tick_q <= tick_q + 16'h3a7;
            ext_done <= 1'b0;
            if (ext_req_q) begin
                live_q <= 1'b1;
                wait_q <= ext_addr_q[3:1];
            end else if (live_q && wait_q != 3'h0) begin
                wait_q <= wait_q - 3'h1;
            end else if (live_q) begin
                live_q <= 1'b0;
                ext_done <= 1'b1;
            end
        end
    end
    // Data is valid only with done; otherwise it keeps moving so stale values are caught.
    assign ext_rdata = ext_done ? (ext_addr_q[15:0] ^ 16'hc35a) : tick_q;
endmodule // orad_ext_model

// >>> tb_top.sv
`timescale 1ns/100ps
`include "orad_map.vh"
module tb_top;
    logic ref_clk = 0, rstn = 0, cpu_req = 0, cpu_we = 0, cpu_byte = 0, hsel = 0, hwrite = 0;
    logic [2:0] op_mode = 0, m;
    logic [23:0] cpu_addr = 0, ext_addr_q, a;
    logic [15:0] cpu_wdata = 0, cpu_rdata_q, ext_rdata, ext_wdata_q, rd, d;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
    logic [1:0] htrans = 0;
    logic cpu_done_q, ext_req_q, ext_we_q, ext_byte_q, ext_done, hreadyout, hresp, b, rb;
    wire hready;
    logic [7:0] mm [0:8191];
    int failures = 0, n_compared = 0, seed = 32'h62df58a1, k, o, w0, a2;
    assign hready = hreadyout;
    always #20 ref_clk = ~ref_clk;
    orad_top u_dut (.ref_clk, .rstn, .op_mode, .cpu_req, .cpu_we, .cpu_byte, .cpu_addr,
        .cpu_wdata, .cpu_done_q, .cpu_rdata_q, .ext_req_q, .ext_we_q, .ext_byte_q, .ext_addr_q,
        .ext_wdata_q, .ext_done, .ext_rdata, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready, .hrdata, .hreadyout, .hresp);
    orad_ext_model u_ext (.ref_clk, .rstn, .ext_req_q, .ext_addr_q, .ext_done, .ext_rdata);
    task check(input logic [31:0] got, exp, input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task give_verdict;
        $display("compared %0d, failed %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // One single bus transfer; the data phase follows the accepted address phase.
    task ahb(input logic wr, input logic [31:0] ad, dat);
        hsel <= 1;
        htrans <= 2'b10;
        haddr <= ad;
        hwrite <= wr;
        do @(posedge ref_clk); while (!hready);
        hsel <= 0;
        htrans <= 2'b00;
        hwdata <= dat;
        do @(posedge ref_clk); while (!hready);
        q = hrdata;
    endtask
    // One core access; k counts edges from the take edge to the done edge.
    task acc(input logic [2:0] md, input logic w, bt, input logic [23:0] ad, input logic [15:0] dt);
        op_mode <= md;
        cpu_we <= w;
        cpu_byte <= bt;
        cpu_addr <= ad;
        cpu_wdata <= dt;
        cpu_req <= 1;
        @(posedge ref_clk);
        cpu_req <= 0;
        k = 0;
        do begin @(posedge ref_clk); k++; end while (!cpu_done_q && k < 50);
        if (!cpu_done_q) begin
            failures++;
            $display("[FAIL] %0t core access not answered", $time);
        end
        rd = cpu_rdata_q;
        @(posedge ref_clk);
    endtask
    function logic [23:0] wa(input logic [2:0] md, input int off);
        return (md inside {3, 4, 6}) ? `ORAD_WIDE_LO + off : {4'h0, `ORAD_NARROW_LO} + off;
    endfunction
    function logic [15:0] exp_rd(input int off, input logic bt);
        return bt ? {mm[off], 8'h00} : {mm[off & ~1], mm[off | 1]};
    endfunction
    // Byte writes land on one lane only; word writes fill both.
    task put(input int off, input logic bt, input logic [15:0] dt);
        mm[off & ~(bt ? 0 : 1)] = dt[15:8];
        if (!bt) mm[off | 1] = dt[7:0];
    endtask
    // Bound the run well beyond what the sequence needs.
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        $display("[FAIL] %0t watchdog expired", $time);
        give_verdict;
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        rstn <= 1;
        @(posedge ref_clk);
        ahb(0, 32'h3ffc8, 0);
        check(q, 32'h0b, "sysctl reset");
        ahb(1, 32'h100, 32'h55);
        ahb(0, 32'h100, 0);
        check(q, 32'h0, "unmapped");
        $display("test registers done");
        for (int i = 0; i < 40; i++) begin
            m = 3'(1 + $unsigned($random(seed)) % 7);
            o = (i == 0) ? 0 : (i == 1) ? 8191 : $unsigned($random(seed)) % 8192;
            {b, rb} = 2'($random(seed));
            w0 = o & ~1;
            a2 = b ? o : w0;
            d = 16'($random(seed));
            acc(m, 1, 0, wa(m, w0), d);
            put(w0, 0, d);
            d = 16'($random(seed));
            acc(m, 1, b, wa(m, a2), d);
            put(a2, b, d);
            a2 = rb ? o : w0;
            acc(m, 0, rb, wa(m, a2), 0);
            check(rd, exp_rd(a2, rb), "storage read");
            check(k, 2, "storage states");
        end
        $display("test storage done");
        ahb(1, 32'h3ffc8, 32'h0a);
        ahb(0, 32'h3ffc8, 0);
        check(q, 32'h0a, "sysctl write");
        for (int md = 0; md < 7; md++) begin
            a = wa(3'(md), 2 * md + 16);
            acc(3'(md), 0, 0, a, 0);
            check(rd, a[15:0] ^ 16'hc35a, "forwarded read");
            check(ext_addr_q, a, "forwarded address");
            check({ext_we_q, ext_byte_q}, 2'b00, "forwarded read kind");
            ahb(0, 32'h3ffcc, 0);
            check(q, 32'h20 | md, "status after forward");
            d = 16'($random(seed));
            acc(3'(md), 1, 1, a + 24'h1, d);
            check({ext_we_q, ext_byte_q, ext_wdata_q}, {2'b11, d}, "forwarded write");
        end
        acc(7, 1, 0, wa(7, 0), 16'h1234);
        acc(7, 0, 0, wa(7, 0), 0);
        check(rd, 16'hffff, "blank read");
        ahb(0, 32'h3ffcc, 0);
        check(q, 32'h47, "status after blank");
        ahb(1, 32'h3ffc8, 32'h0b);
        acc(7, 0, 0, wa(7, 0), 0);
        check(rd, exp_rd(0, 0), "write dropped");
        $display("test disabled done");
        ahb(1, 32'h3ffc8, 32'h0a);
        rstn <= 0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1;
        @(posedge ref_clk);
        ahb(0, 32'h3ffc8, 0);
        check(q, 32'h0b, "enable after reset");
        $display("test reset done");
        give_verdict;
    end
endmodule // tb_top
